// >>> inc/acs_regs.vh
// Character codes, command codes and timing for the ASCII serial command host.
// Assumes the includer is Verilog-2005 or SystemVerilog; definitions only.
`ifndef ACS_REGS_VH
`define ACS_REGS_VH

// ====================================================================
// Frame characters
`define ACS_CH_START 8'h21
`define ACS_CH_COMMA 8'h2c
`define ACS_CH_CR 8'h0d
`define ACS_CH_LF 8'h0a
`define ACS_CH_DOT 8'h2e
`define ACS_CH_COLON 8'h3a
`define ACS_CH_F 8'h46
`define ACS_CH_G 8'h47
`define ACS_CH_A 8'h41
`define ACS_CH_R 8'h52
`define ACS_CH_C 8'h43
`define ACS_CH_M 8'h4d
`define ACS_CH_W 8'h57
`define ACS_CH_N 8'h4e
`define ACS_CH_ONE 8'h31
`define ACS_CH_EIGHT 8'h38
`define ACS_CH_ZERO 8'h30
`define ACS_CH_NINE 8'h39
`define ACS_CH_UA 8'h41
`define ACS_CH_UF 8'h46
`define ACS_CH_LA 8'h61
`define ACS_CH_LF_HEX 8'h66
`define ACS_HEX_UPPER_OFS 8'h37
`define ACS_HEX_LOWER_OFS 8'h57
`define ACS_DIGIT_HI 4'h3
`define ACS_NIB_TEN 4'ha

// ====================================================================
// Addresses
`define ACS_ADDR_BCAST 8'h00
`define ACS_ADDR_DEFAULT 8'h11

// ====================================================================
// Host command codes, multi-drop prefix length and body lengths
`define ACS_CMD_FLOW 3'h0
`define ACS_CMD_GAS 3'h1
`define ACS_CMD_ALARM 3'h2
`define ACS_CMD_LIMIT 3'h3
`define ACS_CMD_MEMW 3'h4
`define ACS_LEN_PREFIX 5'h04
`define ACS_LEN_SHORT 5'h01
`define ACS_LEN_ALARM 5'h02
`define ACS_LEN_LIMIT 5'h0f
`define ACS_LEN_MEMW 5'h09

// ====================================================================
// Reply field positions
`define ACS_POS_TAG1 1
`define ACS_POS_TAG2 2
`define ACS_POS_CODE 3
`define ACS_POS_GAS 2

// ====================================================================
// Timing
`define ACS_CLK_KHZ 20000
`define ACS_REPLY_TIMEOUT_MS 100

`endif

// >>> test/acs_dev_model.sv
// Behavioural flow meter on the serial link, answering host frames.
// Assumes byte links on clk; slow stalls, wrong corrupts reply address.
`timescale 1ns/10ps

module acs_dev_model
(
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Test knobs
  input wire slow,
  input wire wrong,
  // Bytes from host
  input wire [7:0] tx_data,
  input wire tx_valid,
  output reg tx_ready,
  // Bytes to host
  output reg [7:0] rx_data,
  output reg rx_valid
);
  reg [7:0] b [0:31];
  reg [7:0] r [0:47];
  reg [7:0] own_r;
  reg md;
  integer n, rn, rp, dly;

  // ==========
  // Character helpers
  function [3:0] hv(input [7:0] c);
    hv = (c > 8'h39) ? c[3:0] + 4'h9 : c[3:0];
  endfunction
  function [7:0] hc(input [3:0] v);
    hc = (v < 4'ha) ? 8'h30 + {4'h0, v} : 8'h37 + {4'h0, v};
  endfunction
  task put(input [7:0] c);
  begin
    r[rn] = c;
    rn = rn + 1;
  end
  endtask
  task puts(input string t);
    integer i;
  begin
    for (i = 0; i < t.len(); i = i + 1)
      put(t[i]);
  end
  endtask

  // ==========
  // Frame decode, execute and reply build
  task take_frame;
    integer s, j;
    reg [7:0] a;
  begin
    md = (b[0] == 8'h21);
    s = md ? 4 : 0;
    a = {hv(b[1]), hv(b[2])};
    rn = 0;
    rp = 0;
    dly = slow ? 20 : 2;
    if (!md || a == own_r || a == 8'h00)
    begin
      if (b[s] == 8'h4d && {hv(b[s+7]), hv(b[s+8])} != 8'h00)
        own_r = {hv(b[s+7]), hv(b[s+8])};
      if (md && a != 8'h00)
      begin
        put(8'h21);
        put(hc(a[7:4] ^ {3'h0, wrong}));
        put(hc(a[3:0]));
        put(8'h2c);
      end
      if (!md || a != 8'h00)
      begin
        case (b[s])
          8'h46: puts("50.0");
          8'h47: puts("G 3 AIR");
          8'h41:
            if (b[s+1] == 8'h52)
              puts("AR:N");
            else
            begin
              puts("AC:");
              for (j = s + 4; j < n; j = j + 1)
                put(b[j]);
            end
          default:
            for (j = s; j < n; j = j + 1)
              put(b[j]);
        endcase
        put(8'h0d);
      end
    end
  end
  endtask

  // ==========
  // Receive host bytes and stream the reply
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      own_r = 8'h11;
      n = 0;
      rn = 0;
      rp = 0;
      dly = 0;
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end
    else
    begin
      tx_ready <= slow ? ($urandom % 2 == 1) : 1'b1;
      if (tx_valid && tx_ready && tx_data != 8'h0a)
      begin
        if (tx_data == 8'h21)
          n = 0;
        if (tx_data == 8'h0d)
        begin
          take_frame;
          n = 0; // Next frame starts empty; p2p has no start char
        end
        else if (n < 32)
        begin
          b[n] = tx_data;
          n = n + 1;
        end
      end
      if (dly > 0)
        dly = dly - 1;
      if (dly == 0 && rp < rn)
      begin
        rx_valid <= 1'b1;
        rx_data <= r[rp];
        rp = rp + 1;
      end
      else
      begin
        rx_valid <= 1'b0;
        rx_data <= ~rx_data; // Idle line never repeats a value
      end
    end
  end
endmodule

// >>> test/acs_host_sva.sv
// Checker for the host controller ports.
// Assumes one clock and the bind at the foot of this file.
`timescale 1ns/10ps

module acs_host_sva
(
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Request side
  input wire req_valid,
  input wire req_ready_r,
  input wire [2:0] req_cmd,
  input wire [7:0] req_addr,
  input wire req_multi_drop,
  input wire [7:0] req_new_addr,
  input wire sole_device,
  // Byte link and results
  input wire [7:0] tx_data_r,
  input wire tx_valid_r,
  input wire tx_ready,
  input wire req_refused_r,
  input wire rsp_done_r
);
  reg md_r;

  // ==========
  // Mode of the frame being sent
  always @(posedge clk or negedge reset_n)
    if (!reset_n)
      md_r <= 1'b0;
    else if (req_valid && req_ready_r)
      md_r <= req_multi_drop;

  // ==========
  // Properties
  chk_no_line_feed: assert property (@(posedge clk) disable iff (!reset_n)
    tx_valid_r |-> tx_data_r != 8'h0a) else $error("Line feed sent");
  chk_printable_only: assert property (@(posedge clk) disable iff (!reset_n)
    tx_valid_r |-> (tx_data_r inside {[8'h20:8'h7e], 8'h0d})) else $error("Byte not printable");
  chk_tx_held: assert property (@(posedge clk) disable iff (!reset_n)
    tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_data_r)) else $error("Byte dropped early");
  chk_md_start: assert property (@(posedge clk) disable iff (!reset_n)
    req_valid && req_ready_r && req_multi_drop && req_cmd != 3'h4
    |-> ##[1:4] (tx_valid_r && tx_data_r == 8'h21)) else $error("No start char");
  chk_p2p_no_start: assert property (@(posedge clk) disable iff (!reset_n)
    tx_valid_r && !md_r |-> tx_data_r != 8'h21) else $error("Start char in p2p");
  chk_p2p_cmd_first: assert property (@(posedge clk) disable iff (!reset_n)
    req_valid && req_ready_r && !req_multi_drop && req_cmd == 3'h0
    |-> ##[1:4] (tx_valid_r && tx_data_r == 8'h46)) else $error("Command not first");
  chk_refuse_zero: assert property (@(posedge clk) disable iff (!reset_n)
    req_valid && req_ready_r && req_cmd == 3'h4 && req_new_addr == 8'h00
    |=> req_refused_r) else $error("Address 00 not refused");
  chk_refuse_crowd: assert property (@(posedge clk) disable iff (!reset_n)
    req_valid && req_ready_r && req_cmd == 3'h4 && req_multi_drop && req_addr == 8'h00 && !sole_device
    |=> req_refused_r) else $error("Crowded broadcast not refused");
  chk_done_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    rsp_done_r |=> !rsp_done_r) else $error("Done longer than one cycle");
endmodule

bind acs_host acs_host_sva u_chk (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
  .req_ready_r(req_ready_r), .req_cmd(req_cmd), .req_addr(req_addr), .req_multi_drop(req_multi_drop),
  .req_new_addr(req_new_addr), .sole_device(sole_device), .tx_data_r(tx_data_r), .tx_valid_r(tx_valid_r),
  .tx_ready(tx_ready), .req_refused_r(req_refused_r), .rsp_done_r(rsp_done_r));

// >>> test/tb_acs_host.sv
// Self-checking bench for the host controller against the meter model.
// Assumes acs_regs.vh on the include path and the checker bound in.
`timescale 1ns/10ps
`include "acs_regs.vh"

module tb_acs_host;
  reg clk, reset_n, req_valid, req_multi_drop, sole_device, slow, wrong;
  reg [2:0] req_cmd;
  reg [7:0] req_addr, req_new_addr, g;
  reg [15:0] req_lim_hi, req_lim_lo;
  reg [4:0] rsp_rd_idx;
  reg [31:0] lim;
  wire req_ready_r, tx_valid_r, tx_ready, rx_valid, req_refused_r, rsp_done_r, rsp_timeout_r;
  wire alarm_seen_r, alarm_none_r;
  wire [7:0] tx_data_r, rx_data, rsp_rd_char_r;
  wire [5:0] rsp_len_r;
  wire [3:0] gas_table_r;
  reg [7:0] exp_q [$];
  integer mismatches, cmp_count, i;
  string s;

  // ==========
  // Design and meter model
  acs_host #(.REPLY_TO_CYC(200)) dut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
    .req_ready_r(req_ready_r), .req_cmd(req_cmd), .req_addr(req_addr), .req_multi_drop(req_multi_drop),
    .req_lim_hi(req_lim_hi), .req_lim_lo(req_lim_lo), .req_new_addr(req_new_addr),
    .sole_device(sole_device), .tx_data_r(tx_data_r), .tx_valid_r(tx_valid_r), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .req_refused_r(req_refused_r), .rsp_done_r(rsp_done_r),
    .rsp_timeout_r(rsp_timeout_r), .rsp_len_r(rsp_len_r), .rsp_rd_idx(rsp_rd_idx),
    .rsp_rd_char_r(rsp_rd_char_r), .alarm_seen_r(alarm_seen_r), .alarm_none_r(alarm_none_r),
    .gas_table_r(gas_table_r));
  acs_dev_model u_dev (.clk(clk), .reset_n(reset_n), .slow(slow), .wrong(wrong), .tx_data(tx_data_r),
    .tx_valid(tx_valid_r), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid));

  // ==========
  // Compare, verdict, request and reply-text tasks
  task chk(input [7:0] got, input [7:0] x);
  begin
    cmp_count = cmp_count + 1;
    if (got !== x)
    begin
      mismatches = mismatches + 1;
      $display("BAD %0t got %h expected %h", $time, got, x);
    end
  end
  endtask
  task test_done;
  begin
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  // Expected note: kind (0 done, 1 refused, 2 timeout) and length, 3f = any
  task do_req(input [2:0] c, input [7:0] a, input m, input [7:0] na, input [7:0] x);
    integer k;
  begin
    slow = ($urandom % 2 == 1);
    req_cmd = c;
    req_addr = a;
    req_multi_drop = m;
    req_new_addr = na;
    req_valid = 1'b1;
    exp_q.push_back(x);
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    for (k = 0; k < 800 && req_ready_r !== 1'b1; k = k + 1)
    begin
      @(posedge clk);
      #1;
    end
  end
  endtask
  task chk_txt(input string t);
    integer j;
  begin
    for (j = 0; j < t.len(); j = j + 1)
    begin
      rsp_rd_idx = j[4:0];
      @(posedge clk);
      #1;
      chk(rsp_rd_char_r, t[j]);
    end
  end
  endtask

  // ==========
  // Result watcher takes the oldest note per result pulse
  always @(negedge clk)
    if (rsp_done_r === 1'b1 || rsp_timeout_r === 1'b1 || req_refused_r === 1'b1)
    begin
      g = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hff;
      chk({rsp_timeout_r, req_refused_r, (g[5:0] == 6'h3f) ? 6'h3f : rsp_len_r}, g);
    end

  // ==========
  // Clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches = mismatches + 1;
    $display("BAD %0t watchdog expired", $time);
    test_done;
  end

  // ==========
  // Main sequence
  initial
  begin
    {reset_n, req_valid, req_multi_drop, sole_device, slow, wrong} = 6'h00;
    {req_cmd, req_addr, req_new_addr, rsp_rd_idx} = 24'h000000;
    {req_lim_hi, req_lim_lo} = 32'h00000000;
    mismatches = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk);
    #1;
    reset_n = 1'b1;
    void'($urandom(32'hd6495168));
    do_req(`ACS_CMD_FLOW, 8'h11, 1'b0, 8'h00, 8'h04);
    chk_txt("50.0");
    do_req(`ACS_CMD_FLOW, 8'h11, 1'b1, 8'h00, 8'h04);
    do_req(`ACS_CMD_GAS, 8'h11, 1'b1, 8'h00, 8'h07);
    chk_txt("G 3 AIR");
    chk({4'h0, gas_table_r}, 8'h03);
    do_req(`ACS_CMD_ALARM, 8'h11, 1'b1, 8'h00, 8'h04);
    chk({6'h00, alarm_seen_r, alarm_none_r}, 8'h03);
    for (i = 0; i < 8; i = i + 1)
      lim = {lim[27:0], 4'($urandom % 10)};
    {req_lim_hi, req_lim_lo} = lim;
    s = $sformatf("AC:%h.%h,%h.%h", lim[31:24], lim[23:16], lim[15:8], lim[7:0]);
    do_req(`ACS_CMD_LIMIT, 8'h11, 1'b1, 8'h00, 8'h0e);
    chk_txt(s);
    do_req(`ACS_CMD_FLOW, 8'h12, 1'b1, 8'h00, 8'hbf);
    do_req(`ACS_CMD_MEMW, 8'h11, 1'b1, 8'h12, 8'h09);
    chk_txt("MW,118,12");
    do_req(`ACS_CMD_FLOW, 8'h12, 1'b1, 8'h00, 8'h04);
    do_req(`ACS_CMD_MEMW, 8'h12, 1'b1, 8'h00, 8'h7f);
    do_req(`ACS_CMD_MEMW, 8'h12, 1'b1, 8'h12, 8'h7f);
    do_req(`ACS_CMD_MEMW, 8'h00, 1'b1, 8'h2a, 8'h7f);
    sole_device = 1'b1;
    do_req(`ACS_CMD_MEMW, 8'h00, 1'b1, 8'h2a, 8'h3f);
    do_req(`ACS_CMD_FLOW, 8'h2a, 1'b1, 8'h00, 8'h04);
    wrong = 1'b1;
    do_req(`ACS_CMD_FLOW, 8'h2a, 1'b1, 8'h00, 8'hbf);
    wrong = 1'b0;
    do_req(`ACS_CMD_GAS, 8'h2a, 1'b0, 8'h00, 8'h07);
    chk_txt("G 3 AIR");
    chk(8'(exp_q.size()), 8'h00);
    test_done;
  end
endmodule

// >>> verilog/acs_hex_enc.v
// Byte to two printable upper-case hex characters.
// Assumes a same-clock consumer; purely combinational.
`timescale 1ns/10ps
`include "acs_regs.vh"

module acs_hex_enc
(
  // Value in
  input wire [7:0] value,
  // Characters out
  output wire [7:0] char_hi,
  output wire [7:0] char_lo
);

  // Nibble to ASCII hex digit
  function [7:0] nib_char;
    input [3:0] n;
    begin
      if (n < `ACS_NIB_TEN)
        nib_char = {`ACS_DIGIT_HI, n};
      else
        nib_char = {4'h0, n} + `ACS_HEX_UPPER_OFS;
    end
  endfunction

  // Both halves
  assign char_hi = nib_char(value[7:4]);
  assign char_lo = nib_char(value[3:0]);

endmodule

// >>> verilog/acs_host.v
// Host-side controller for an ASCII serial command device: builds command
// frames, sends them byte by byte and collects the reply text.
// Assumes a byte transmitter and receiver on clk (serial framing outside).
`timescale 1ns/10ps
`include "acs_regs.vh"

module acs_host
#(
  parameter RSP_DEPTH = 32,
  parameter RSP_AW = 5,
  parameter TO_W = 22,
  parameter [TO_W-1:0] REPLY_TO_CYC = `ACS_REPLY_TIMEOUT_MS * `ACS_CLK_KHZ
)
(
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Command request
  input wire req_valid,
  output reg req_ready_r,
  input wire [2:0] req_cmd,
  input wire [7:0] req_addr,
  input wire req_multi_drop,
  input wire [15:0] req_lim_hi,
  input wire [15:0] req_lim_lo,
  input wire [7:0] req_new_addr,
  input wire sole_device,
  // Byte transmitter
  output reg [7:0] tx_data_r,
  output reg tx_valid_r,
  input wire tx_ready,
  // Byte receiver
  input wire [7:0] rx_data,
  input wire rx_valid,
  // Results
  output reg req_refused_r,
  output reg rsp_done_r,
  output reg rsp_timeout_r,
  output reg [RSP_AW:0] rsp_len_r,
  input wire [RSP_AW-1:0] rsp_rd_idx,
  output reg [7:0] rsp_rd_char_r,
  output reg alarm_seen_r,
  output reg alarm_none_r,
  output reg [3:0] gas_table_r
);

  localparam ST_IDLE = 2'h0;
  localparam ST_SEND = 2'h1;
  localparam ST_WAIT = 2'h2;

  reg [1:0] state_r;
  reg [2:0] cmd_r;
  reg [7:0] addr_r;
  reg md_r;
  reg [15:0] hi_r;
  reg [15:0] lo_r;
  reg [7:0] new_r;
  reg [4:0] pos_r;
  reg [TO_W-1:0] to_cnt_r;
  reg [RSP_AW:0] len_r;
  reg [255:0] used_r;
  reg [7:0] rsp_mem [0:RSP_DEPTH-1];

  wire [7:0] ah;
  wire [7:0] al;
  wire [7:0] nh;
  wire [7:0] nl;
  wire fr_start;
  wire fr_body;
  wire [7:0] fr_char;
  wire fr_end;
  wire [7:0] fr_addr;

  // ====================================================================
  // Hex encoders for target and new address
  acs_hex_enc u_enc_addr
  (
    .value(addr_r),
    .char_hi(ah),
    .char_lo(al)
  );

  acs_hex_enc u_enc_new
  (
    .value(new_r),
    .char_hi(nh),
    .char_lo(nl)
  );

  // ====================================================================
  // Reply front end
  acs_rx_front u_front
  (
    .clk(clk),
    .reset_n(reset_n),
    .multi_drop(md_r),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .frame_start_r(fr_start),
    .body_valid_r(fr_body),
    .body_char_r(fr_char),
    .frame_end_r(fr_end),
    .hdr_addr_r(fr_addr)
  );

  // BCD digit to ASCII
  function [7:0] dig;
    input [3:0] d;
    begin
      dig = {`ACS_DIGIT_HI, d};
    end
  endfunction

  // Body length per command
  function [4:0] body_len;
    input [2:0] c;
    begin
      case (c)
        `ACS_CMD_ALARM: body_len = `ACS_LEN_ALARM;
        `ACS_CMD_LIMIT: body_len = `ACS_LEN_LIMIT;
        `ACS_CMD_MEMW: body_len = `ACS_LEN_MEMW;
        default: body_len = `ACS_LEN_SHORT;
      endcase
    end
  endfunction

  // ====================================================================
  // Frame character at the current position
  reg [7:0] cur_char;
  reg [4:0] pre;
  reg [4:0] bi;
  reg [4:0] flen;
  always @*
  begin
    pre = md_r ? `ACS_LEN_PREFIX : 5'h00;
    bi = pos_r - pre;
    flen = pre + body_len(cmd_r);
    cur_char = `ACS_CH_CR;
    if (pos_r < pre)
    begin
      // Start, two hex address characters, comma
      case (pos_r[1:0])
        2'h0: cur_char = `ACS_CH_START;
        2'h1: cur_char = ah;
        2'h2: cur_char = al;
        default: cur_char = `ACS_CH_COMMA;
      endcase
    end
    else if (pos_r < flen)
    begin
      // Printable command and argument text
      case (cmd_r)
        `ACS_CMD_FLOW: cur_char = `ACS_CH_F;
        `ACS_CMD_GAS: cur_char = `ACS_CH_G;
        `ACS_CMD_ALARM: cur_char = (bi == 5'h00) ? `ACS_CH_A : `ACS_CH_R;
        `ACS_CMD_LIMIT:
          case (bi)
            5'h00: cur_char = `ACS_CH_A;
            5'h02: cur_char = `ACS_CH_C;
            5'h04: cur_char = dig(hi_r[15:12]);
            5'h05: cur_char = dig(hi_r[11:8]);
            5'h06: cur_char = `ACS_CH_DOT;
            5'h07: cur_char = dig(hi_r[7:4]);
            5'h08: cur_char = dig(hi_r[3:0]);
            5'h0a: cur_char = dig(lo_r[15:12]);
            5'h0b: cur_char = dig(lo_r[11:8]);
            5'h0c: cur_char = `ACS_CH_DOT;
            5'h0d: cur_char = dig(lo_r[7:4]);
            5'h0e: cur_char = dig(lo_r[3:0]);
            default: cur_char = `ACS_CH_COMMA;
          endcase
        default:
          case (bi)
            5'h00: cur_char = `ACS_CH_M;
            5'h01: cur_char = `ACS_CH_W;
            5'h03: cur_char = `ACS_CH_ONE;
            5'h04: cur_char = `ACS_CH_ONE;
            5'h05: cur_char = `ACS_CH_EIGHT;
            5'h07: cur_char = nh;
            5'h08: cur_char = nl;
            default: cur_char = `ACS_CH_COMMA;
          endcase
      endcase
    end
  end

  // Request checks on address assignment
  wire is_memw = (req_cmd == `ACS_CMD_MEMW);
  wire bad_new = (req_new_addr == `ACS_ADDR_BCAST) || used_r[req_new_addr];
  wire bad_bc = (req_addr == `ACS_ADDR_BCAST) && req_multi_drop && !sole_device;
  wire refuse = is_memw && (bad_new || bad_bc);
  wire last_char = (pos_r == flen);
  wire bcast = md_r && (addr_r == `ACS_ADDR_BCAST);
  wire mine = !md_r || (fr_addr == addr_r);

  // ====================================================================
  // Sequencer: take, send, wait for reply
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= ST_IDLE;
      req_ready_r <= 1'b1;
      cmd_r <= `ACS_CMD_FLOW;
      addr_r <= `ACS_ADDR_DEFAULT;
      md_r <= 1'b0;
      hi_r <= 16'h0000;
      lo_r <= 16'h0000;
      new_r <= 8'h00;
      pos_r <= 5'h00;
      tx_data_r <= 8'h00;
      tx_valid_r <= 1'b0;
      to_cnt_r <= {TO_W{1'b0}};
      req_refused_r <= 1'b0;
      rsp_done_r <= 1'b0;
      rsp_timeout_r <= 1'b0;
      used_r <= 256'h0;
    end
    else
    begin
      req_refused_r <= 1'b0;
      rsp_done_r <= 1'b0;
      rsp_timeout_r <= 1'b0;
      case (state_r)
        ST_IDLE:
          if (req_valid)
          begin
            if (refuse)
              req_refused_r <= 1'b1;
            else
            begin
              cmd_r <= req_cmd;
              addr_r <= req_addr;
              md_r <= req_multi_drop;
              hi_r <= req_lim_hi;
              lo_r <= req_lim_lo;
              new_r <= req_new_addr;
              pos_r <= 5'h00;
              req_ready_r <= 1'b0;
              state_r <= ST_SEND;
            end
          end
        ST_SEND:
          if (!tx_valid_r)
          begin
            tx_data_r <= cur_char;
            tx_valid_r <= 1'b1;
          end
          else if (tx_ready)
          begin
            tx_valid_r <= 1'b0;
            pos_r <= pos_r + 5'h01;
            if (last_char)
            begin
              to_cnt_r <= {TO_W{1'b0}};
              if (cmd_r == `ACS_CMD_MEMW)
                used_r[new_r] <= 1'b1;
              if (bcast)
              begin
                // Nobody answers a broadcast
                rsp_done_r <= 1'b1;
                req_ready_r <= 1'b1;
                state_r <= ST_IDLE;
              end
              else
                state_r <= ST_WAIT;
            end
          end
        ST_WAIT:
          if (fr_end && mine)
          begin
            rsp_done_r <= 1'b1;
            req_ready_r <= 1'b1;
            state_r <= ST_IDLE;
          end
          else if (to_cnt_r >= REPLY_TO_CYC - 1'b1)
          begin
            // Silent device: give up
            rsp_timeout_r <= 1'b1;
            req_ready_r <= 1'b1;
            state_r <= ST_IDLE;
          end
          else
            to_cnt_r <= to_cnt_r + 1'b1;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ====================================================================
  // Reply text store
  always @(posedge clk)
  begin
    if (state_r == ST_WAIT && fr_body && len_r < RSP_DEPTH)
      rsp_mem[len_r[RSP_AW-1:0]] <= fr_char;
  end

  // Reply length, decoded fields and read port
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      len_r <= {(RSP_AW+1){1'b0}};
      rsp_len_r <= {(RSP_AW+1){1'b0}};
      rsp_rd_char_r <= 8'h00;
      alarm_seen_r <= 1'b0;
      alarm_none_r <= 1'b0;
      gas_table_r <= 4'h0;
    end
    else
    begin
      rsp_rd_char_r <= rsp_mem[rsp_rd_idx];
      if (state_r == ST_IDLE && req_valid && !refuse)
        len_r <= {(RSP_AW+1){1'b0}};
      else if (fr_start && !fr_body)
        // A p2p first character both starts and fills the body
        len_r <= {(RSP_AW+1){1'b0}};
      else if (state_r == ST_WAIT && fr_body && len_r < RSP_DEPTH)
        len_r <= len_r + 1'b1;
      if (state_r == ST_WAIT && fr_end && mine)
      begin
        rsp_len_r <= len_r;
        // Alert-state tag, colon, code
        if (cmd_r == `ACS_CMD_ALARM && rsp_mem[0] == `ACS_CH_A && rsp_mem[`ACS_POS_TAG1] == `ACS_CH_R
            && rsp_mem[`ACS_POS_TAG2] == `ACS_CH_COLON)
        begin
          alarm_seen_r <= 1'b1;
          alarm_none_r <= (rsp_mem[`ACS_POS_CODE] == `ACS_CH_N);
        end
        // Table number after the echoed command and a space
        if (cmd_r == `ACS_CMD_GAS && rsp_mem[0] == `ACS_CH_G)
          gas_table_r <= rsp_mem[`ACS_POS_GAS][3:0];
      end
    end
  end

endmodule

// >>> verilog/acs_rx_front.v
// Reply receive front end: strips line feeds, finds the frame header and
// delivers body characters. Assumes rx bytes arrive from logic on clk.
`timescale 1ns/10ps
`include "acs_regs.vh"

module acs_rx_front
(
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Mode and byte in
  input wire multi_drop,
  input wire [7:0] rx_data,
  input wire rx_valid,
  // Frame events out
  output reg frame_start_r,
  output reg body_valid_r,
  output reg [7:0] body_char_r,
  output reg frame_end_r,
  output reg [7:0] hdr_addr_r
);

  localparam S_HUNT = 3'h0;
  localparam S_ADR1 = 3'h1;
  localparam S_ADR2 = 3'h2;
  localparam S_COMMA = 3'h3;
  localparam S_BODY = 3'h4;
  localparam S_BAD = 3'h5;

  reg [2:0] state_r;

  // Hex character decode, valid flag on top
  function [4:0] hex_val;
    input [7:0] ch;
    reg [7:0] diff;
    begin
      diff = 8'h00;
      hex_val = 5'h00;
      if (ch >= `ACS_CH_ZERO && ch <= `ACS_CH_NINE)
        hex_val = {1'b1, ch[3:0]};
      else if (ch >= `ACS_CH_UA && ch <= `ACS_CH_UF)
      begin
        diff = ch - `ACS_HEX_UPPER_OFS;
        hex_val = {1'b1, diff[3:0]};
      end
      else if (ch >= `ACS_CH_LA && ch <= `ACS_CH_LF_HEX)
      begin
        diff = ch - `ACS_HEX_LOWER_OFS;
        hex_val = {1'b1, diff[3:0]};
      end
    end
  endfunction

  wire [4:0] hv = hex_val(rx_data);

  // Header walk and body delivery
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= S_HUNT;
      frame_start_r <= 1'b0;
      body_valid_r <= 1'b0;
      body_char_r <= 8'h00;
      frame_end_r <= 1'b0;
      hdr_addr_r <= 8'h00;
    end
    else
    begin
      frame_start_r <= 1'b0;
      body_valid_r <= 1'b0;
      frame_end_r <= 1'b0;
      if (rx_valid && rx_data != `ACS_CH_LF)
      begin
        if (multi_drop && rx_data == `ACS_CH_START)
        begin
          frame_start_r <= 1'b1;
          state_r <= S_ADR1;
        end
        else
        begin
          case (state_r)
            S_HUNT:
              if (!multi_drop)
              begin
                // No header on a point-to-point line
                frame_start_r <= 1'b1;
                if (rx_data == `ACS_CH_CR)
                  frame_end_r <= 1'b1;
                else
                begin
                  body_valid_r <= 1'b1;
                  body_char_r <= rx_data;
                  state_r <= S_BODY;
                end
              end
            S_ADR1:
              if (hv[4])
              begin
                hdr_addr_r <= {hv[3:0], 4'h0};
                state_r <= S_ADR2;
              end
              else
                state_r <= S_BAD;
            S_ADR2:
              if (hv[4])
              begin
                hdr_addr_r <= {hdr_addr_r[7:4], hv[3:0]};
                state_r <= S_COMMA;
              end
              else
                state_r <= S_BAD;
            S_COMMA:
              state_r <= (rx_data == `ACS_CH_COMMA) ? S_BODY : S_BAD;
            S_BODY:
              if (rx_data == `ACS_CH_CR)
              begin
                frame_end_r <= 1'b1;
                state_r <= S_HUNT;
              end
              else
              begin
                body_valid_r <= 1'b1;
                body_char_r <= rx_data;
              end
            S_BAD:
              if (rx_data == `ACS_CH_CR)
                state_r <= S_HUNT;
            default:
              state_r <= S_HUNT;
          endcase
        end
      end
    end
  end

endmodule
